// [pinfunc_pkg.sv]
// constants for the usb, dma and pin function configuration block
package pinfunc_pkg;
  // configuration register offsets
  localparam logic [7:0] OFS_STRAP_STATUS = 8'h70;
  localparam logic [7:0] OFS_FAST_DMA = 8'h71;
  localparam logic [7:0] OFS_PIN_FUNC = 8'h72;
  localparam logic [7:0] OFS_REQ_SRC = 8'h73;
  // reset values
  localparam logic [7:0] RST_FAST_DMA = 8'h00;
  localparam logic [7:0] RST_PIN_FUNC = 8'h80;
  localparam logic [7:0] RST_REQ_SRC = 8'h00;
  // writable bit masks, reserved bits read as zero
  localparam logic [7:0] MASK_FAST_DMA = 8'hef;
  localparam logic [7:0] MASK_PIN_FUNC = 8'hef;
  localparam logic [7:0] MASK_REQ_SRC = 8'h06;
  // pin function register fields
  localparam int PF_USB_EN = 7;
  localparam int PF_PORT0_EN = 6;
  localparam int PF_PORT1_EN = 5;
  localparam int PF_WAKE_DIR = 3;
  localparam int PF_DACK_HI_DIR = 2;
  localparam int PF_ACK_ENC_EN = 1;
  localparam int PF_IRQ_ALT = 0;
  // request source register fields
  localparam int RS_IRQ12 = 2;
  localparam int RS_WAKE = 1;
  // strap status field
  localparam int KS_INTERNAL = 3;
  // encoder output when no acknowledge is active
  localparam logic [2:0] ENC_IDLE = 3'h0;
endpackage

// [pin_sync.sv]
// two flop synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_out
);
  logic [W-1:0] meta_ff; // first stage, read only by second stage

  // two stage capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      pin_sync_out <= '0;
    end
    else
    begin
      meta_ff <= pin_in;
      pin_sync_out <= meta_ff;
    end
  end
endmodule // pin_sync

// [ack_encoder.sv]
// priority encoder of active low dma acknowledges onto a three bit code
`timescale 1ns/100ps
module ack_encoder
  import pinfunc_pkg::*;
(
  input wire logic [7:0] ack_n,
  output logic [2:0] code,
  output logic any_ack
);
  // lowest numbered active acknowledge wins
  always_comb
  begin
    code = ENC_IDLE;
    any_ack = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      if (!ack_n[i])
      begin
        code = 3'(i);
        any_ack = 1'b1;
      end
    end
  end
endmodule // ack_encoder

// [usb_dma_pin_function_config.sv]
// configuration registers and pin multiplexing for usb, dma and irq pins
`timescale 1ns/100ps
module usb_dma_pin_function_config
  import pinfunc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // configuration access port
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata_ff,
  // straps and internal status
  input wire logic kbd_internal_strap,
  input wire logic ps2_mouse_en,
  // board dma request pins, shared with usb port 0
  input wire logic [1:0] board_dma_request_i,
  output logic [1:0] board_dma_request_o_ff,
  output logic [1:0] board_dma_request_oe_ff,
  // board irq pins, shared with usb port 1
  input wire logic [1:0] board_irq_input_i,
  output logic [1:0] board_irq_input_o_ff,
  output logic [1:0] board_irq_input_oe_ff,
  // alternate irq pins
  input wire logic [1:0] alt_irq_pin_i,
  // irq12 pin
  input wire logic irq12_i,
  // wake pin
  input wire logic wake_pin_zero_i,
  output logic wake_pin_zero_o_ff,
  output logic wake_pin_zero_oe_ff,
  input wire logic wake_drive_val,
  // dack 7:6 pins
  input wire logic [1:0] dack_hi_pin_i,
  output logic [1:0] dack_hi_pin_o_ff,
  output logic [1:0] dack_hi_pin_oe_ff,
  // usb core side
  input wire logic [1:0] port0_tx,
  input wire logic port0_tx_en,
  input wire logic [1:0] port1_tx,
  input wire logic port1_tx_en,
  output logic [1:0] port0_rx_ff,
  output logic [1:0] port1_rx_ff,
  output logic usb_enable_ff,
  // dma and interrupt controller side
  input wire logic [7:0] dma_ack_n,
  output logic [1:0] dma_request_ff,
  output logic [1:0] board_irq_ff,
  output logic [7:0] fast_dma_ch_ff,
  output logic [1:0] dack_hi_in_ff,
  output logic mouse_serial_data_ff,
  output logic [2:0] encoded_dma_ack_ff,
  output logic encoded_dma_ack_oe_ff
);
  logic [7:0] fast_dma_ff; // fast channel select
  logic [7:0] pin_func_ff; // usb and pin function control
  logic [7:0] req_src_ff; // request source select
  logic [1:0] dreq_s; // synced dma request pins
  logic [1:0] irq_s; // synced irq pins
  logic [1:0] alt_s; // synced alternate irq pins
  logic [1:0] dack_s; // synced dack pins
  logic irq12_s; // synced irq12
  logic wake_s; // synced wake pin
  logic [2:0] enc_code; // encoder output
  logic enc_any; // some ack active
  logic port0_on; // usb port 0 owns request pins
  logic port1_on; // usb port 1 owns irq pins
  logic alt_valid; // alternate irq routing allowed
  logic [1:0] nxt_dma_request; // next dma request to controller
  logic [1:0] nxt_board_irq; // next irq to controller
  logic [7:0] nxt_rdata; // read mux

  // pin synchronisers
  pin_sync #(.W(10)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({board_dma_request_i, board_irq_input_i, alt_irq_pin_i,
      dack_hi_pin_i, irq12_i, wake_pin_zero_i}),
    .pin_sync_out({dreq_s, irq_s, alt_s, dack_s, irq12_s, wake_s})
  );

  // acknowledge encoder
  ack_encoder u_enc (
    .ack_n(dma_ack_n),
    .code(enc_code),
    .any_ack(enc_any)
  );

  // usb ports take the pins only while usb is enabled
  assign port0_on = pin_func_ff[PF_USB_EN] & pin_func_ff[PF_PORT0_EN];
  assign port1_on = pin_func_ff[PF_USB_EN] & pin_func_ff[PF_PORT1_EN];
  // alternate irq pins need encoder or internal controller
  assign alt_valid = pin_func_ff[PF_IRQ_ALT] &
    (pin_func_ff[PF_ACK_ENC_EN] | kbd_internal_strap);

  // fast dma register, reserved bit held zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fast_dma_ff <= RST_FAST_DMA;
    else if (cfg_wr && cfg_addr == OFS_FAST_DMA)
      fast_dma_ff <= cfg_wdata & MASK_FAST_DMA;
  end

  // pin function register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_func_ff <= RST_PIN_FUNC;
    else if (cfg_wr && cfg_addr == OFS_PIN_FUNC)
      pin_func_ff <= cfg_wdata & MASK_PIN_FUNC;
  end

  // request source register, only bits 2:1 kept
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      req_src_ff <= RST_REQ_SRC;
    else if (cfg_wr && cfg_addr == OFS_REQ_SRC)
      req_src_ff <= cfg_wdata & MASK_REQ_SRC;
  end

  // read data mux, strap bit is read only
  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (cfg_addr)
      OFS_STRAP_STATUS: nxt_rdata[KS_INTERNAL] = kbd_internal_strap;
      OFS_FAST_DMA: nxt_rdata = fast_dma_ff;
      OFS_PIN_FUNC: nxt_rdata = pin_func_ff;
      OFS_REQ_SRC: nxt_rdata = req_src_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // read data register, loaded on a read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_rdata_ff <= 8'h00;
    else if (cfg_rd)
      cfg_rdata_ff <= nxt_rdata;
  end

  // dma request sources
  always_comb
  begin
    nxt_dma_request = port0_on ? 2'b00 : dreq_s;
    if (req_src_ff[RS_IRQ12])
      nxt_dma_request[0] = irq12_s;
    else if (req_src_ff[RS_WAKE] && !ps2_mouse_en)
      nxt_dma_request[0] = wake_s;
  end

  // irq sources to interrupt controller
  always_comb
  begin
    if (alt_valid)
      nxt_board_irq = alt_s;
    else if (port1_on)
      nxt_board_irq = 2'b00;
    else
      nxt_board_irq = irq_s;
  end

  // controller side outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dma_request_ff <= 2'b00;
      board_irq_ff <= 2'b00;
      fast_dma_ch_ff <= RST_FAST_DMA;
      usb_enable_ff <= RST_PIN_FUNC[PF_USB_EN];
      dack_hi_in_ff <= 2'b11;
      mouse_serial_data_ff <= 1'b0;
    end
    else
    begin
      dma_request_ff <= nxt_dma_request;
      board_irq_ff <= nxt_board_irq;
      fast_dma_ch_ff <= fast_dma_ff;
      usb_enable_ff <= pin_func_ff[PF_USB_EN];
      // input path of dack pins while they are inputs
      dack_hi_in_ff <= pin_func_ff[PF_DACK_HI_DIR] ? 2'b11 : dack_s;
      // wake pin carries mouse data whenever mouse is on
      mouse_serial_data_ff <= ps2_mouse_en & wake_s;
    end
  end

  // usb port pins, inputs until a port drives
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      board_dma_request_oe_ff <= 2'b00;
      board_dma_request_o_ff <= 2'b00;
      board_irq_input_oe_ff <= 2'b00;
      board_irq_input_o_ff <= 2'b00;
      port0_rx_ff <= 2'b00;
      port1_rx_ff <= 2'b00;
    end
    else
    begin
      board_dma_request_oe_ff <= {2{port0_on & port0_tx_en}};
      board_dma_request_o_ff <= port0_tx;
      board_irq_input_oe_ff <= {2{port1_on & port1_tx_en}};
      board_irq_input_o_ff <= port1_tx;
      port0_rx_ff <= port0_on ? dreq_s : 2'b00;
      port1_rx_ff <= port1_on ? irq_s : 2'b00;
    end
  end

  // wake and dack pin drivers, encoded ack
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_pin_zero_oe_ff <= 1'b0;
      wake_pin_zero_o_ff <= 1'b0;
      dack_hi_pin_oe_ff <= 2'b00;
      dack_hi_pin_o_ff <= 2'b11;
      encoded_dma_ack_ff <= ENC_IDLE;
      encoded_dma_ack_oe_ff <= 1'b0;
    end
    else
    begin
      wake_pin_zero_oe_ff <= pin_func_ff[PF_WAKE_DIR];
      wake_pin_zero_o_ff <= wake_drive_val;
      dack_hi_pin_oe_ff <= {2{pin_func_ff[PF_DACK_HI_DIR]}};
      dack_hi_pin_o_ff <= dma_ack_n[7:6];
      // code valid only while some acknowledge is active
      encoded_dma_ack_ff <= pin_func_ff[PF_ACK_ENC_EN] ? enc_code
        : ENC_IDLE;
      encoded_dma_ack_oe_ff <= pin_func_ff[PF_ACK_ENC_EN] & enc_any;
    end
  end

  // checks
  property p_fast_reserved;
    @(posedge clk) disable iff (!rst_n)
    cfg_wr && cfg_addr == OFS_FAST_DMA |=> fast_dma_ff[4] == 1'b0
      && fast_dma_ff[3:0] == $past(cfg_wdata[3:0]);
  endproperty
  a_fast_reserved: assert property (p_fast_reserved)
    else $error("fast dma register write wrong");

  property p_usb_port0;
    @(posedge clk) disable iff (!rst_n)
    port0_on && !req_src_ff[RS_IRQ12] && !req_src_ff[RS_WAKE]
      |=> dma_request_ff == 2'b00;
  endproperty
  a_usb_port0: assert property (p_usb_port0)
    else $error("dma request leaked while port 0 owns pins");

  property p_irq12_req;
    @(posedge clk) disable iff (!rst_n)
    req_src_ff[RS_IRQ12] |=> dma_request_ff[0] == $past(irq12_s);
  endproperty
  a_irq12_req: assert property (p_irq12_req)
    else $error("irq12 not routed as dma request");

  property p_wake_req;
    @(posedge clk) disable iff (!rst_n)
    !req_src_ff[RS_IRQ12] && req_src_ff[RS_WAKE] && !ps2_mouse_en
      |=> dma_request_ff[0] == $past(wake_s);
  endproperty
  a_wake_req: assert property (p_wake_req)
    else $error("wake pin not routed as dma request");

  property p_port1_irq;
    @(posedge clk) disable iff (!rst_n)
    port1_on && !alt_valid |=> board_irq_ff == 2'b00
      && port1_rx_ff == $past(irq_s);
  endproperty
  a_port1_irq: assert property (p_port1_irq)
    else $error("irq pins not handed to usb port 1");

  property p_usb_input;
    @(posedge clk) disable iff (!rst_n)
    !port0_tx_en |=> board_dma_request_oe_ff == 2'b00;
  endproperty
  a_usb_input: assert property (p_usb_input)
    else $error("usb pin driven without request");

  property p_dack_dir;
    @(posedge clk) disable iff (!rst_n)
    cfg_wr && cfg_addr == OFS_PIN_FUNC
      |=> ##1 dack_hi_pin_oe_ff == {2{$past(cfg_wdata[PF_DACK_HI_DIR], 2)}};
  endproperty
  a_dack_dir: assert property (p_dack_dir)
    else $error("dack direction does not follow register");

  property p_enc;
    @(posedge clk) disable iff (!rst_n)
    pin_func_ff[PF_ACK_ENC_EN] && !dma_ack_n[5] && &dma_ack_n[4:0]
      |=> encoded_dma_ack_ff == 3'h5 && encoded_dma_ack_oe_ff;
  endproperty
  a_enc: assert property (p_enc)
    else $error("acknowledge encoding wrong");

  property p_alt;
    @(posedge clk) disable iff (!rst_n)
    pin_func_ff[PF_IRQ_ALT] && !pin_func_ff[PF_ACK_ENC_EN]
      && !kbd_internal_strap && !port1_on |=> board_irq_ff == $past(irq_s);
  endproperty
  a_alt: assert property (p_alt)
    else $error("alternate irq pins used while not valid");

  property p_strap;
    @(posedge clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == OFS_STRAP_STATUS
      |=> cfg_rdata_ff == {4'h0, $past(kbd_internal_strap), 3'h0};
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap status read wrong");

  property p_src_res;
    @(posedge clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == OFS_REQ_SRC |=> (cfg_rdata_ff & 8'hf9) == 8'h00;
  endproperty
  a_src_res: assert property (p_src_res)
    else $error("request select reserved bits not zero");
endmodule // usb_dma_pin_function_config

// [board_model.sv]
// board side model: peripherals on shared pins, ack decoder
`timescale 1ns/100ps
module board_model (
  input wire logic [6:0] dev_o,
  input wire logic [6:0] dev_oe,
  input wire logic [6:0] per_drv,
  output logic [6:0] pin_lvl,
  input wire logic [2:0] enc_code,
  input wire logic enc_oe,
  output logic [7:0] dec_ack_n
);
  // pin level: device drive wins, else the peripheral level
  always_comb
  begin
    for (int i = 0; i < 7; i++)
      pin_lvl[i] = dev_oe[i] ? dev_o[i] : per_drv[i];
  end
  // three to eight decoder of the encoded acknowledge
  always_comb
  begin
    dec_ack_n = 8'hff;
    if (enc_oe)
      dec_ack_n[enc_code] = 1'b0;
  end
endmodule // board_model

// [testbench.sv]
// self-checking bench for the usb, dma and pin function block
`timescale 1ns/100ps
module testbench;
  import pinfunc_pkg::*;
  logic clk, rst_n, cfg_wr, cfg_rd, strap, mouse, irq12, wake_val;
  logic p0_en, p1_en, enc_oe, usb_en, msd;
  logic [7:0] cfg_addr, cfg_wdata, rdata, ack_n, fast, dec_n, d;
  logic [1:0] p0_tx, p1_tx, alt, req, birq, dk_in, p0_rx, p1_rx;
  logic [6:0] dev_o, dev_oe, per, lvl;
  logic [2:0] enc;
  logic [31:0] seed;
  int miscompares, samples_checked;
  // clock source, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  usb_dma_pin_function_config u_usb_dma_pin_function_config (
    .clk(clk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata_ff(rdata),
    .kbd_internal_strap(strap), .ps2_mouse_en(mouse),
    .board_dma_request_i(lvl[1:0]), .board_dma_request_o_ff(dev_o[1:0]),
    .board_dma_request_oe_ff(dev_oe[1:0]), .board_irq_input_i(lvl[3:2]),
    .board_irq_input_o_ff(dev_o[3:2]), .board_irq_input_oe_ff(dev_oe[3:2]),
    .alt_irq_pin_i(alt), .irq12_i(irq12), .wake_pin_zero_i(lvl[4]),
    .wake_pin_zero_o_ff(dev_o[4]), .wake_pin_zero_oe_ff(dev_oe[4]),
    .wake_drive_val(wake_val), .dack_hi_pin_i(lvl[6:5]),
    .dack_hi_pin_o_ff(dev_o[6:5]), .dack_hi_pin_oe_ff(dev_oe[6:5]),
    .port0_tx(p0_tx), .port0_tx_en(p0_en), .port1_tx(p1_tx),
    .port1_tx_en(p1_en), .port0_rx_ff(p0_rx), .port1_rx_ff(p1_rx),
    .usb_enable_ff(usb_en), .dma_ack_n(ack_n), .dma_request_ff(req),
    .board_irq_ff(birq), .fast_dma_ch_ff(fast), .dack_hi_in_ff(dk_in),
    .mouse_serial_data_ff(msd), .encoded_dma_ack_ff(enc),
    .encoded_dma_ack_oe_ff(enc_oe));
  board_model u_board_model (.dev_o(dev_o), .dev_oe(dev_oe),
    .per_drv(per), .pin_lvl(lvl), .enc_code(enc), .enc_oe(enc_oe),
    .dec_ack_n(dec_n));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected irq path to the interrupt controller
  function automatic logic [1:0] exp_irq(input logic [7:0] pf,
    input logic s, input logic [1:0] pins, input logic [1:0] a);
    if (pf[0] && (pf[1] || s))
      return a;
    return (pf[7] && pf[5]) ? 2'b00 : pins;
  endfunction
  // value comparison, counted
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // config write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= v;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  // config read and compare
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    @(posedge clk);
    #1 chk(rdata, exp);
  endtask
  // let pin and register paths settle
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  // verdict and end of run
  task automatic results();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog against hangs
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
  // main sequence
  initial
  begin
    seed = 32'h0710594b;
    miscompares = 0;
    samples_checked = 0;
    {rst_n, cfg_wr, cfg_rd, strap, mouse, irq12, wake_val} = 7'h0;
    {p0_en, p1_en, cfg_addr, cfg_wdata, p0_tx, p1_tx, alt} = 24'h0;
    per = 7'h7f;
    ack_n = 8'hff;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // reset values
    rd(OFS_FAST_DMA, 8'h00);
    rd(OFS_PIN_FUNC, 8'h80);
    rd(OFS_REQ_SRC, 8'h00);
    chk({dev_oe, usb_en}, 8'h01);
    $display("end of reset test");
    // register access
    for (int i = 0; i < 6; i++)
    begin
      d = rnd();
      wr(OFS_FAST_DMA, d);
      rd(OFS_FAST_DMA, d & 8'hef);
      chk(fast, d & 8'hef);
    end
    wr(OFS_REQ_SRC, 8'hfa);
    rd(OFS_REQ_SRC, 8'h02);
    wr(OFS_STRAP_STATUS, 8'hff);
    rd(OFS_STRAP_STATUS, 8'h00);
    rd(8'h9c, 8'h00);
    $display("end of register test");
    // usb port 0 on the request pins, request from irq12 and wake
    wr(OFS_PIN_FUNC, 8'hc0);
    wr(OFS_REQ_SRC, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      d = rnd();
      per <= d[6:0];
      p0_tx <= d[7:6];
      p0_en <= d[0];
      settle();
      chk({dev_oe[1:0], p0_rx, req, 2'b0},
        {{2{d[0]}}, d[0] ? d[7:6] : d[1:0], 4'h0});
    end
    p0_en <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_REQ_SRC, 8'h04);
      d = rnd();
      irq12 <= d[0];
      per <= d[7:1];
      settle();
      chk({7'h0, req[0]}, {7'h0, d[0]});
      wr(OFS_REQ_SRC, 8'h02);
      mouse <= 1'b0;
      settle();
      chk({7'h0, req[0]}, {7'h0, d[5]});
      mouse <= 1'b1;
      settle();
      chk({6'h0, req[0], msd}, {6'h0, 1'b0, d[5]});
    end
    $display("end of port 0 test");
    // usb port 1 on the irq pins
    wr(OFS_PIN_FUNC, 8'ha0);
    for (int i = 0; i < 4; i++)
    begin
      d = rnd();
      per <= d[6:0];
      p1_tx <= d[7:6];
      p1_en <= d[1];
      settle();
      chk({dev_oe[3:2], p1_rx, birq, 2'b0},
        {{2{d[1]}}, d[1] ? d[7:6] : d[3:2], 4'h0});
    end
    p1_en <= 1'b0;
    // alternate irq pins against encoder and strap
    for (int j = 0; j < 8; j++)
    begin
      d = rnd();
      strap <= j[2];
      alt <= d[1:0];
      per <= d[7:1];
      wr(OFS_PIN_FUNC, {6'h0, j[1:0]});
      settle();
      chk({6'h0, birq},
        {6'h0, exp_irq({6'h0, j[1:0]}, j[2], d[4:3], d[1:0])});
      rd(OFS_STRAP_STATUS, {4'h0, j[2], 3'h0});
    end
    // wake and dack 7:6 direction
    d = rnd();
    wake_val <= d[0];
    ack_n <= d;
    wr(OFS_PIN_FUNC, 8'h0c);
    settle();
    chk({dev_oe[6:4], dev_o[4], 4'h0}, {3'h7, d[0], 4'h0});
    chk({6'h0, dev_o[6:5]}, {6'h0, d[7:6]});
    per <= d[6:0];
    wr(OFS_PIN_FUNC, 8'h00);
    settle();
    chk({dev_oe[6:4], 3'h0, dk_in}, {6'h0, d[6:5]});
    $display("end of direction test");
    // acknowledge encoder with the board decoder
    wr(OFS_PIN_FUNC, 8'h02);
    for (int i = 0; i < 8; i++)
    begin
      d = rnd();
      ack_n <= (d | ((8'h1 << i) - 8'h1)) & ~(8'h1 << i);
      settle();
      chk({enc_oe, enc, 4'h0}, {1'b1, i[2:0], 4'h0});
      chk(dec_n, ~(8'h1 << i));
    end
    ack_n <= 8'hff;
    settle();
    chk({7'h0, enc_oe}, 8'h00);
    $display("end of encoder test");
    results();
  end
endmodule // testbench
